// ### hdl/cac_array.sv
// Summary of operation
// - Qualifying pin edge in capture mode copies the 16-bit counter into compare pair.
// - Rising, falling or both capture enables select capture and its edges.
// - Events set flag; interrupt request needs both flag and module interrupt enable.
// - Hardware sets event flags and never clears them; software clears them.
// - A new capture always overwrites the previous captured value.
// - Comparator plus hit enable: 16-bit counter equal to pair sets event flag.
// - Low-byte write disables comparator, high-byte write enables it again.
// - Flip, hit and comparator enables: pin inverts on each 16-bit match.
// - Pin inversion is done in hardware at the match, interrupt optional.
// - Unchanged compare value toggles again after counter wraps to it.
// - Pulse-width mode: output low while counter low byte below compare low.
// - Pulse-width duty in high byte, copied to low byte at low-byte wrap.
// - All modules share one counter as their time base.
// - Only module 4 offers watchdog; otherwise it keeps all other modes.
// - Watchdog 16-bit match on module 4 generates an internal reset.
// - Watchdog reset is internal only, never drives the external reset pin.
// - Watchdog reset gated by watchdog reset enable bit 40H of mode register.
// - Watchdog works with module 4 in either compare mode, e.g. value 4CH.
// - Watchdog decoded on module 4 with comparator and hit enable, flip any.
// - Pulse-width output does not depend on the module interrupt enable.
`timescale 1ns/1ps
`default_nettype none

module cac_array (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire cac_pkg::cac_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cac_pkg::CAC_MODULES-1:0] module_pin_in,
  output logic [cac_pkg::CAC_MODULES-1:0] module_pin_out,
  output logic [cac_pkg::CAC_MODULES-1:0] module_pin_oe_n,
  output logic irq_req,
  output logic watchdog_reset
);
  import cac_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cac_byte_t counter_lower;
  cac_byte_t counter_upper;
  logic counter_run;
  logic counter_fresh;
  logic watchdog_reset_enable;
  logic watchdog_seen;
  logic [CAC_MODULES-1:0] module_event_flag;
  cac_byte_t module_mode_reg [CAC_MODULES];
  cac_byte_t compare_low_byte [CAC_MODULES];
  cac_byte_t compare_high_byte [CAC_MODULES];
  logic [CAC_MODULES-1:0] pin_level;
  logic [CAC_MODULES-1:0] pin_rise;
  logic [CAC_MODULES-1:0] pin_fall;
  logic [CAC_MODULES-1:0] capture_hit;
  logic [CAC_MODULES-1:0] match_hit;
  logic [CAC_MODULES-1:0] pwm_on;
  logic [CAC_MODULES-1:0] event_set;
  logic [CAC_MODULES-1:0] wr_mode;
  logic [CAC_MODULES-1:0] wr_low;
  logic [CAC_MODULES-1:0] wr_high;
  cac_count_t counter_value;
  cac_count_t next_counter;
  logic low_wrap;
  logic wdt_fire;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr_en;
  logic wr_control;
  logic wr_mode_reg;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic mapped;
  cac_byte_t wbyte;

  // One wait state: response is registered on the same edge that pready rises
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready;
  assign wbyte = pwdata[7:0];
  assign wr_control = wr_en && (paddr == CAC_OFS_CONTROL);
  assign wr_mode_reg = wr_en && (paddr == CAC_OFS_MODE);
  assign wr_cnt_low = wr_en && (paddr == CAC_OFS_CNT_LOW);
  assign wr_cnt_high = wr_en && (paddr == CAC_OFS_CNT_HIGH);

  genvar gi;
  generate
    for (gi = 0; gi < CAC_MODULES; gi++) begin : g_dec
      localparam cac_addr_t OFS = cac_addr_t'(gi) * CAC_MOD_STRIDE;
      assign wr_mode[gi] = wr_en && (paddr == CAC_OFS_MOD_MODE + OFS);
      assign wr_low[gi] = wr_en && (paddr == CAC_OFS_CMP_LOW + OFS);
      assign wr_high[gi] = wr_en && (paddr == CAC_OFS_CMP_HIGH + OFS);
    end
  endgenerate

  always_comb begin
    mapped = 1'b0;
    if (paddr == CAC_OFS_CONTROL || paddr == CAC_OFS_MODE) begin
      mapped = 1'b1;
    end
    if (paddr == CAC_OFS_CNT_LOW || paddr == CAC_OFS_CNT_HIGH) begin
      mapped = 1'b1;
    end
    if (paddr == CAC_OFS_STATUS) begin
      mapped = 1'b1;
    end
    for (int i = 0; i < CAC_MODULES; i++) begin
      if (paddr == CAC_OFS_MOD_MODE + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        mapped = 1'b1;
      end
      if (paddr == CAC_OFS_CMP_LOW + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        mapped = 1'b1;
      end
      if (paddr == CAC_OFS_CMP_HIGH + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        mapped = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_value;

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      CAC_OFS_CONTROL: begin
        rd_value[CAC_MODULES-1:0] = module_event_flag;
        rd_value[CAC_CTL_RUN_BIT] = counter_run;
      end
      CAC_OFS_MODE: rd_value[CAC_MODE_WDT_BIT] = watchdog_reset_enable;
      CAC_OFS_CNT_LOW: rd_value[7:0] = counter_lower;
      CAC_OFS_CNT_HIGH: rd_value[7:0] = counter_upper;
      CAC_OFS_STATUS: begin
        rd_value[CAC_MODULES-1:0] = module_pin_out;
        rd_value[CAC_STAT_WDT_BIT] = watchdog_seen;
      end
      default: rd_value = 32'h0000_0000;
    endcase
    for (int i = 0; i < CAC_MODULES; i++) begin
      if (paddr == CAC_OFS_MOD_MODE + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        rd_value[7:0] = module_mode_reg[i];
      end
      if (paddr == CAC_OFS_CMP_LOW + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        rd_value[7:0] = compare_low_byte[i];
      end
      if (paddr == CAC_OFS_CMP_HIGH + cac_addr_t'(i) * CAC_MOD_STRIDE) begin
        rd_value[7:0] = compare_high_byte[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready && !pwrite) begin
        prdata <= mapped ? rd_value : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Global control and mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_run <= 1'b0;
      watchdog_reset_enable <= 1'b0;
    end else begin
      if (wr_control) begin
        counter_run <= wbyte[CAC_CTL_RUN_BIT];
      end
      if (wr_mode_reg) begin
        watchdog_reset_enable <= wbyte[CAC_MODE_WDT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared counter
  // ----------------------------------------------------------------
  assign counter_value = {counter_upper, counter_lower};
  assign next_counter = counter_value + 16'h0001;
  assign low_wrap = counter_run && (counter_lower == CAC_LOW_MAX);

  // Single time base for every module
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_lower <= CAC_BYTE_RST;
      counter_upper <= CAC_BYTE_RST;
      counter_fresh <= 1'b0;
    end else begin
      counter_fresh <= counter_run || wr_cnt_low || wr_cnt_high;
      if (wr_cnt_low || wr_cnt_high) begin
        if (wr_cnt_low) begin
          counter_lower <= wbyte;
        end
        if (wr_cnt_high) begin
          counter_upper <= wbyte;
        end
      end else if (counter_run) begin
        counter_lower <= next_counter[7:0];
        counter_upper <= next_counter[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-module compare and capture
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < CAC_MODULES; gi++) begin : g_mod
      logic cmp_en;
      logic cap_mode;

      cac_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_raw(module_pin_in[gi]),
        .level(pin_level[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );

      assign cmp_en = module_mode_reg[gi][CAC_MM_COMPARATOR];
      assign cap_mode = module_mode_reg[gi][CAC_MM_RISING] || module_mode_reg[gi][CAC_MM_FALLING];
      assign capture_hit[gi] = (module_mode_reg[gi][CAC_MM_RISING] && pin_rise[gi])
        || (module_mode_reg[gi][CAC_MM_FALLING] && pin_fall[gi]);
      // Counter step gate keeps a held count from matching twice
      assign match_hit[gi] = cmp_en && module_mode_reg[gi][CAC_MM_HIT] && counter_fresh
        && (counter_value == {compare_high_byte[gi], compare_low_byte[gi]});
      assign pwm_on[gi] = cmp_en && module_mode_reg[gi][CAC_MM_PWM] && !cap_mode;
      assign event_set[gi] = capture_hit[gi] || match_hit[gi];

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          module_mode_reg[gi] <= CAC_BYTE_RST;
        end else if (wr_mode[gi]) begin
          module_mode_reg[gi] <= wbyte & CAC_MM_MASK;
        end else if (wr_low[gi]) begin
          module_mode_reg[gi][CAC_MM_COMPARATOR] <= 1'b0;
        end else if (wr_high[gi]) begin
          module_mode_reg[gi][CAC_MM_COMPARATOR] <= 1'b1;
        end
      end

      // Capture beats duty reload, which beats a low-byte software write
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          compare_low_byte[gi] <= CAC_BYTE_RST;
          compare_high_byte[gi] <= CAC_BYTE_RST;
        end else if (capture_hit[gi]) begin
          compare_low_byte[gi] <= counter_lower;
          compare_high_byte[gi] <= counter_upper;
        end else begin
          if (pwm_on[gi] && low_wrap) begin
            compare_low_byte[gi] <= compare_high_byte[gi];
          end else if (wr_low[gi]) begin
            compare_low_byte[gi] <= wbyte;
          end
          if (wr_high[gi]) begin
            compare_high_byte[gi] <= wbyte;
          end
        end
      end

      // Pin is driven only in output-producing compare modes
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          module_pin_out[gi] <= 1'b0;
          module_pin_oe_n[gi] <= 1'b1;
        end else begin
          module_pin_oe_n[gi] <= !(pwm_on[gi] || (cmp_en && module_mode_reg[gi][CAC_MM_FLIP]));
          if (pwm_on[gi]) begin
            // Independent of the interrupt enable
            module_pin_out[gi] <= !(counter_lower < compare_low_byte[gi]);
          end else if (match_hit[gi] && module_mode_reg[gi][CAC_MM_FLIP]) begin
            module_pin_out[gi] <= !module_pin_out[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event flags and interrupt request
  // ----------------------------------------------------------------
  // Writing zero clears a flag, but a same-cycle event still sets it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      module_event_flag <= '0;
    end else begin
      if (wr_control) begin
        module_event_flag <= (module_event_flag & wbyte[CAC_MODULES-1:0]) | event_set;
      end else begin
        module_event_flag <= module_event_flag | event_set;
      end
    end
  end

  logic [CAC_MODULES-1:0] irq_enables;

  always_comb begin
    for (int i = 0; i < CAC_MODULES; i++) begin
      irq_enables[i] = module_mode_reg[i][CAC_MM_IRQ];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |(module_event_flag & irq_enables);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog on the last module
  // ----------------------------------------------------------------
  // Flip enable is don't-care; pwm setups never reach it, capture setups only with comparator and hit set
  assign wdt_fire = watchdog_reset_enable && match_hit[CAC_WDT_MODULE]
    && !module_mode_reg[CAC_WDT_MODULE][CAC_MM_PWM];

  // Internal pulse only, nothing here reaches a reset pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_reset <= 1'b0;
      watchdog_seen <= 1'b0;
    end else begin
      watchdog_reset <= wdt_fire;
      if (wdt_fire) begin
        watchdog_seen <= 1'b1;
      end else if (wr_control && wbyte[7]) begin
        watchdog_seen <= 1'b0;
      end
    end
  end

endmodule : cac_array

`default_nettype wire

// ### hdl/cac_pkg.sv
package cac_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int CAC_MODULES = 5;
  localparam int CAC_WDT_MODULE = 4;

  typedef logic [7:0] cac_byte_t;
  typedef logic [15:0] cac_count_t;
  typedef logic [11:0] cac_addr_t;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam cac_addr_t CAC_OFS_CONTROL = 12'h000;
  localparam cac_addr_t CAC_OFS_MODE = 12'h004;
  localparam cac_addr_t CAC_OFS_CNT_LOW = 12'h008;
  localparam cac_addr_t CAC_OFS_CNT_HIGH = 12'h00c;
  localparam cac_addr_t CAC_OFS_MOD_MODE = 12'h010;
  localparam cac_addr_t CAC_OFS_CMP_LOW = 12'h030;
  localparam cac_addr_t CAC_OFS_CMP_HIGH = 12'h050;
  localparam cac_addr_t CAC_OFS_STATUS = 12'h070;
  localparam cac_addr_t CAC_MOD_STRIDE = 12'h004;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAC_CTL_RUN_BIT = 6;
  localparam int CAC_MODE_WDT_BIT = 6;
  localparam int CAC_MM_COMPARATOR = 6;
  localparam int CAC_MM_RISING = 5;
  localparam int CAC_MM_FALLING = 4;
  localparam int CAC_MM_HIT = 3;
  localparam int CAC_MM_FLIP = 2;
  localparam int CAC_MM_PWM = 1;
  localparam int CAC_MM_IRQ = 0;
  localparam int CAC_STAT_WDT_BIT = 8;

  // ----------------------------------------------------------------
  // Values after reset and fixed values
  // ----------------------------------------------------------------
  localparam cac_byte_t CAC_BYTE_RST = 8'h00;
  localparam cac_count_t CAC_COUNT_RST = 16'h0000;
  localparam cac_byte_t CAC_MM_MASK = 8'h7f;
  localparam cac_byte_t CAC_LOW_MAX = 8'hff;

endpackage : cac_pkg

// ### hdl/cac_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cac_pin_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin_raw,
  output logic level,
  output logic rise,
  output logic fall
);
  import cac_pkg::*;

  logic sync_a;
  logic sync_b;
  logic sync_c;

  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  // Resets to the pulled-up idle level, so no false edge follows reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ----------------------------------------------------------------
  // Accepted level and edge pulses
  // ----------------------------------------------------------------
  // Change only accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b1;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sync_b == sync_c && sync_c != level) begin
        level <= sync_c;
        rise <= sync_c;
        fall <= ~sync_c;
      end
    end
  end

endmodule : cac_pin_sync

`default_nettype wire

// ### test/cac_array_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cac_array_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [cac_pkg::CAC_MODULES-1:0] module_pin_out,
  input wire logic [cac_pkg::CAC_MODULES-1:0] module_pin_oe_n,
  input wire logic irq_req,
  input wire logic watchdog_reset
);
  import cac_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_rst_vals;
    $rose(rst_b) |-> module_pin_oe_n == '1 && !irq_req && !watchdog_reset;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
  property p_rdy_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("access not answered after one wait state");
  property p_rdy_only;
    pready |-> psel && penable;
  endproperty
  a_rdy_only: assert property (p_rdy_only)
    else $error("ready outside an access phase");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready longer than one cycle");
  property p_err_rd;
    pslverr |-> pready && (pwrite || prdata == 32'h0);
  endproperty
  a_err_rd: assert property (p_err_rd)
    else $error("error response malformed");
  property p_wdt_pulse;
    watchdog_reset |=> !watchdog_reset;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("internal reset longer than one cycle");
  property p_flag_hold;
    $fell(irq_req) |-> $past(pwrite && pready, 1) || $past(pwrite && pready, 2);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("irq dropped with no register write");
  property p_one_toggle;
    $changed(module_pin_out) |=> $stable(module_pin_out);
  endproperty
  a_one_toggle: assert property (p_one_toggle)
    else $error("pin changed on two cycles in a row");
endmodule : cac_array_properties

bind cac_array cac_array_properties u_cac_array_properties (.ref_clk, .rst_b, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .module_pin_out, .module_pin_oe_n,
  .irq_req, .watchdog_reset);
`default_nettype wire

// ### test/cac_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module cac_pin_model (
  input wire logic [cac_pkg::CAC_MODULES-1:0] ext_drv,
  input wire logic [cac_pkg::CAC_MODULES-1:0] ext_en,
  input wire logic [cac_pkg::CAC_MODULES-1:0] module_pin_out,
  input wire logic [cac_pkg::CAC_MODULES-1:0] module_pin_oe_n,
  output logic [cac_pkg::CAC_MODULES-1:0] pin_level
);
  import cac_pkg::*;
  // Module drive wins; a released pin floats up through its pull-up
  always_comb begin
    for (int i = 0; i < CAC_MODULES; i++) begin
      if (!module_pin_oe_n[i]) pin_level[i] = module_pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_drv[i];
      else pin_level[i] = 1'b1;
    end
  end
endmodule : cac_pin_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cac_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  cac_addr_t paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [CAC_MODULES-1:0] pin_in;
  logic [CAC_MODULES-1:0] pin_out;
  logic [CAC_MODULES-1:0] pin_oe_n;
  logic [CAC_MODULES-1:0] ext_drv = 5'h00;
  logic [CAC_MODULES-1:0] ext_en = 5'h00;
  logic irq_req;
  logic watchdog_reset;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int wd_pulses = 0;

  cac_array u_cac_array (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .module_pin_in(pin_in), .module_pin_out(pin_out),
    .module_pin_oe_n(pin_oe_n), .irq_req, .watchdog_reset);
  cac_pin_model u_cac_pin_model (.ext_drv, .ext_en, .module_pin_out(pin_out),
    .module_pin_oe_n(pin_oe_n), .pin_level(pin_in));

  always #5 ref_clk = ~ref_clk;

  // Full counter lap in the toggle test dominates the run time
  always @(posedge ref_clk) begin
    cycles++;
    if (watchdog_reset === 1'b1) wd_pulses++;
    if (cycles == 80000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic apb(input logic w, input cac_addr_t a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk({31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input cac_addr_t a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input cac_addr_t a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
  endtask : rd

  function automatic cac_addr_t ofs(input cac_addr_t b, input int n);
    return b + CAC_MOD_STRIDE * cac_addr_t'(n);
  endfunction : ofs

  task automatic mode(input int n, input logic [7:0] v);
    wr(ofs(CAC_OFS_MOD_MODE, n), v);
  endtask : mode

  // Low byte first, so no half-updated pair can match
  task automatic cmp(input int n, input cac_count_t v);
    wr(ofs(CAC_OFS_CMP_LOW, n), v[7:0]);
    wr(ofs(CAC_OFS_CMP_HIGH, n), v[15:8]);
  endtask : cmp

  task automatic ctl(input logic [7:0] v);
    wr(CAC_OFS_CONTROL, v);
  endtask : ctl

  // Stops the counter but keeps all event flags
  task automatic cnt(input cac_count_t v);
    ctl(8'h1f);
    wr(CAC_OFS_CNT_LOW, v[7:0]);
    wr(CAC_OFS_CNT_HIGH, v[15:8]);
  endtask : cnt

  task automatic cap(input cac_count_t x);
    rd(ofs(CAC_OFS_CMP_LOW, 0), {24'h0, x[7:0]});
    rd(ofs(CAC_OFS_CMP_HIGH, 0), {24'h0, x[15:8]});
  endtask : cap

  task automatic s_reset();
    logic [31:0] r;
    logic e;
    chk({27'h0, pin_oe_n}, 32'h1f);
    for (int n = 0; n < CAC_MODULES; n++) begin
      rd(ofs(CAC_OFS_MOD_MODE, n), 32'h0);
      rd(ofs(CAC_OFS_CMP_LOW, n), 32'h0);
      rd(ofs(CAC_OFS_CMP_HIGH, n), 32'h0);
    end
    apb(1'b0, 12'h0fc, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask : s_reset

  task automatic s_capture();
    cac_count_t x;
    logic [7:0] m [3];
    m = '{8'h21, 8'h11, 8'h31};
    x = 16'h0000;
    ext_en[0] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      mode(0, m[k]);
      cnt(16'h1200 + 16'(k));
      ext_drv[0] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      if (m[k][5]) x = 16'h1200 + 16'(k);
      cap(x);
      cnt(16'h3400 + 16'(k));
      ext_drv[0] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      if (m[k][4]) x = 16'h3400 + 16'(k);
      cap(x);
    end
    chk({31'h0, irq_req}, 32'h1);
    repeat (20) @(posedge ref_clk);
    rd(CAC_OFS_CONTROL, 32'h01);
    ctl(8'h00);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq_req}, 32'h0);
  endtask : s_capture

  task automatic s_timer();
    mode(1, 8'h49);
    cnt(16'h001e);
    wr(ofs(CAC_OFS_CMP_LOW, 1), 8'h20);
    rd(ofs(CAC_OFS_MOD_MODE, 1), 32'h09);
    ctl(8'h40);
    repeat (10) @(posedge ref_clk);
    chk({31'h0, irq_req}, 32'h0);
    cnt(16'h001e);
    wr(ofs(CAC_OFS_CMP_HIGH, 1), 8'h00);
    rd(ofs(CAC_OFS_MOD_MODE, 1), 32'h49);
    ctl(8'h40);
    repeat (10) @(posedge ref_clk);
    chk({31'h0, irq_req}, 32'h1);
    rd(CAC_OFS_CONTROL, 32'h42);
  endtask : s_timer

  task automatic s_toggle();
    ctl(8'h00);
    mode(1, 8'h00);
    mode(2, 8'h4c);
    cnt(16'hfff0);
    cmp(2, 16'h0008);
    @(posedge ref_clk);
    chk({27'h0, pin_oe_n}, 32'h1b);
    ctl(8'h40);
    repeat (40) @(posedge ref_clk);
    chk({31'h0, pin_in[2]}, 32'h1);
    chk({31'h0, irq_req}, 32'h0);
    repeat (65536) @(posedge ref_clk);
    rd(CAC_OFS_STATUS, 32'h0);
  endtask : s_toggle

  task automatic s_pwm();
    mode(3, 8'h42);
    cnt(16'h0050);
    cmp(3, 16'h4080);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, pin_in[3]}, 32'h0);
    cnt(16'h0080);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, pin_in[3]}, 32'h1);
    rd(ofs(CAC_OFS_CMP_LOW, 3), 32'h80);
    cnt(16'h00f8);
    ctl(8'h40);
    repeat (20) @(posedge ref_clk);
    cnt(16'h0050);
    rd(ofs(CAC_OFS_CMP_LOW, 3), 32'h40);
    chk({31'h0, pin_in[3]}, 32'h1);
  endtask : s_pwm

  task automatic s_wdt();
    logic [31:0] r;
    logic e;
    mode(3, 8'h00);
    mode(1, 8'h48);
    mode(4, 8'h4c);
    cnt(16'h0010);
    cmp(1, 16'h0020);
    cmp(4, 16'h0020);
    wr(CAC_OFS_MODE, 8'h00);
    ctl(8'h40);
    repeat (30) @(posedge ref_clk);
    chk(wd_pulses, 32'h0);
    cnt(16'h0010);
    wr(CAC_OFS_MODE, 8'h40);
    ctl(8'h40);
    repeat (4) @(posedge ref_clk);
    cmp(4, 16'h0100);
    repeat (20) @(posedge ref_clk);
    chk(wd_pulses, 32'h0);
    repeat (260) @(posedge ref_clk);
    chk(wd_pulses, 32'h1);
    apb(1'b0, CAC_OFS_STATUS, 8'h00, r, e);
    chk({31'h0, r[CAC_STAT_WDT_BIT]}, 32'h1);
    ctl(8'h80);
    apb(1'b0, CAC_OFS_STATUS, 8'h00, r, e);
    chk({31'h0, r[CAC_STAT_WDT_BIT]}, 32'h0);
  endtask : s_wdt

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    s_reset();
    s_capture();
    s_timer();
    s_toggle();
    s_pwm();
    s_wdt();
    test_done();
  end
endmodule : tb
`default_nettype wire
